// ---- logic/bts_pkg.sv ----
// constants and carrier types for the bit-set / bit-test-skip execution block
// assumes a core that hands over one instruction word per instruction cycle
// What this block does
// RQ1 - bit-set forces chosen bit of addressed register to one, one word, one cycle
// RQ2 - access-select 0 uses access bank, 1 uses bank select register bank
// RQ3 - access-select 0 with extended set on: address up to 95 is indexed offset
// RQ4 - test-skip-if-clear decoded by nibble 1011, bit field, access bit, 8-bit address
// RQ5 - test skips only on clear bit: one cycle no skip, two when skipping
// RQ6 - skip discards the already fetched instruction and runs a no-operation instead
// RQ7 - skipping a two-word instruction takes three cycles, flushing both words
// RQ8 - bit-set uses nibble 1000, same fields; no status flag changes
package bts_pkg;
  localparam logic [3:0]  BTS_OP_SET        = 4'h8;
  localparam logic [3:0]  BTS_OP_TEST_CLR   = 4'hB;
  localparam logic [7:0]  BTS_INDEXED_LIMIT = 8'h5F;
  localparam int          BTS_OPC_MSB       = 15;
  localparam int          BTS_BIT_LSB       = 9;
  localparam int          BTS_ACC_POS       = 8;
  localparam logic [11:0] BTS_ADDR_RST      = 12'h000;
  localparam logic [7:0]  BTS_DATA_RST      = 8'h00;

  typedef enum logic [1:0] {BTS_MODE_ACCESS, BTS_MODE_BANKED, BTS_MODE_INDEXED} bts_mode_t;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
    bts_mode_t   mode;
  } bts_wr_t;
endpackage

// ---- logic/bts_exec.sv ----
// execution logic for the bit-set and bit-test-skip-if-clear instructions
// assumes instr_valid marks a decoded word each instruction cycle (clk enable
// is the instruction cycle itself), rd_data holds the addressed register's
// value in that cycle, and next_two_word flags the fetched follower's size
`timescale 1ns/1ps
module bts_exec
  import bts_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic        ext_set_en,
  input  wire logic [7:0]  rd_data,
  input  wire logic        next_two_word,
  output logic [11:0]      rd_addr,
  output bts_wr_t          wr,
  output logic             flush,
  output logic             busy,
  output logic             is_bit_set_op,
  output logic             is_bit_test_skip_clear_op
);

  typedef enum logic [1:0] {BTS_RUN, BTS_NOP1, BTS_NOP2} bts_state_t;

  ////////////////////////////////////////////////////////////////////////
  // field decode and address formation
  logic [3:0]  opc;
  logic [2:0]  bitn;
  logic        acc;
  logic [7:0]  f;
  logic        dec_set;
  logic        dec_tst;
  bts_mode_t   mode_c;
  logic [11:0] addr_c;

  always_comb
  begin
    opc     = instr[BTS_OPC_MSB -: 4];
    bitn    = instr[BTS_BIT_LSB +: 3];
    acc     = instr[BTS_ACC_POS];
    f       = instr[7:0];
    dec_set = (opc == BTS_OP_SET);       // [RQ8]
    dec_tst = (opc == BTS_OP_TEST_CLR);  // [RQ4]
    if (!acc && ext_set_en && (f <= BTS_INDEXED_LIMIT))
    begin
      mode_c = BTS_MODE_INDEXED;          // [RQ3]
      addr_c = {4'h0, f};
    end
    else if (!acc)
    begin
      mode_c = BTS_MODE_ACCESS;           // [RQ2]
      addr_c = (f[7]) ? {4'hF, f} : {4'h0, f};
    end
    else
    begin
      mode_c = BTS_MODE_BANKED;           // [RQ2]
      addr_c = {bank_select_reg, f};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one-hot mask of the selected bit; the same mask sets and tests it
  // a row of small compares instead of a barrel shift keeps the path short
  logic [7:0]  bit_mask;
  genvar       gi;

  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_mask
      assign bit_mask[gi] = (bitn == 3'(gi));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // acceptance; a word offered while a skip is flushing is dropped, not queued
  // rd_data must already hold the addressed register while the word is valid
  bts_state_t  state_reg, state_next;
  logic        act;
  logic        bit_clear;
  logic        skip;
  logic [7:0]  set_data;

  always_comb
  begin
    act       = instr_valid && (state_reg == BTS_RUN);
    bit_clear = ~|(rd_data & bit_mask);
    skip      = act && dec_tst && bit_clear;  // [RQ5]
    set_data  = rd_data | bit_mask;           // [RQ1]
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing; no status flag is touched, so none is an output  [RQ8]
  // the follower's length is taken from next_two_word at the testing edge only
  // busy stays high exactly while offered words are refused
  logic        flush_reg, flush_next;
  logic        busy_reg, busy_next;

  always_comb
  begin
    state_next = state_reg;
    flush_next = 1'b0;
    busy_next  = 1'b0;
    case (state_reg)
      BTS_RUN:
      begin
        // a bit-set, or a test that finds its bit set, leaves the sequencer here
        if (skip)
        begin
          flush_next = 1'b1;                                 // [RQ6]
          busy_next  = 1'b1;
          state_next = next_two_word ? BTS_NOP2 : BTS_NOP1;  // [RQ7]
        end
      end
      BTS_NOP2:
      begin
        // second word of the skipped instruction is flushed too
        flush_next = 1'b1;  // [RQ7]
        busy_next  = 1'b1;
        state_next = BTS_NOP1;
      end
      default:
      begin
        // no-operation cycle in place of the follower
        state_next = BTS_RUN;  // [RQ6]
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= BTS_RUN;
      flush_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      flush_reg <= flush_next;
      busy_reg  <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write port; the merged byte goes back one cycle after the read, so the
  // core must not change the addressed register in between
  // indexed mode only reports f; the core adds it to its own pointer
  bts_wr_t     wr_reg, wr_next;

  always_comb
  begin
    wr_next = '0;
    if (act && dec_set)
    begin
      wr_next.we   = 1'b1;      // [RQ1]
      wr_next.addr = addr_c;    // [RQ2]
      wr_next.data = set_data;  // [RQ1]
      wr_next.mode = mode_c;    // [RQ3]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '{we: 1'b0, addr: BTS_ADDR_RST, data: BTS_DATA_RST, mode: BTS_MODE_ACCESS};
    end
    else
    begin
      wr_reg <= wr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode flags and the last effective address, which holds between words
  // any taken word moves the address, foreign opcodes too
  logic [11:0] rd_addr_reg, rd_addr_next;
  logic        set_reg, set_next;
  logic        tst_reg, tst_next;

  always_comb
  begin
    rd_addr_next = rd_addr_reg;
    set_next     = 1'b0;
    tst_next     = 1'b0;
    if (act)
    begin
      rd_addr_next = addr_c;
      set_next     = dec_set;  // [RQ8]
      tst_next     = dec_tst;  // [RQ4]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_addr_reg <= BTS_ADDR_RST;
      set_reg     <= 1'b0;
      tst_reg     <= 1'b0;
    end
    else
    begin
      rd_addr_reg <= rd_addr_next;
      set_reg     <= set_next;
      tst_reg     <= tst_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the registers
  assign rd_addr                   = rd_addr_reg;
  assign wr                        = wr_reg;
  assign flush                     = flush_reg;
  assign busy                      = busy_reg;
  assign is_bit_set_op             = set_reg;
  assign is_bit_test_skip_clear_op = tst_reg;

endmodule

// ---- sim/bts_exec_sva.sv ----
// checker for the bit-set / bit-test-skip execution block
// sees only the top ports; bound into every bts_exec instance
`timescale 1ns/1ps
module bts_exec_sva
  import bts_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic [3:0]  bank_select_reg,
  input wire logic        ext_set_en,
  input wire logic [7:0]  rd_data,
  input wire logic        next_two_word,
  input wire logic [11:0] rd_addr,
  input wire bts_wr_t     wr,
  input wire logic        flush,
  input wire logic        busy,
  input wire logic        is_bit_set_op,
  input wire logic        is_bit_test_skip_clear_op
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_set_data: assert property (wr.we |->
    wr.data == ($past(rd_data) | (8'h01 << $past(instr[11:9]))))
    else $error("bit-set data wrong");
  a_set_flag: assert property (is_bit_set_op |->
    wr.we && $past(instr[15:12]) == BTS_OP_SET)
    else $error("bit-set decode wrong");
  a_bank_mode: assert property (wr.we && $past(instr[8]) |->
    wr.mode == BTS_MODE_BANKED && wr.addr == {$past(bank_select_reg), $past(instr[7:0])})
    else $error("bank wrong");
  a_indexed_mode: assert property (wr.we && !$past(instr[8]) && $past(ext_set_en)
    && $past(instr[7:0]) <= BTS_INDEXED_LIMIT |-> wr.mode == BTS_MODE_INDEXED)
    else $error("indexed mode missed");
  a_test_flag: assert property (is_bit_test_skip_clear_op |->
    !wr.we && $past(instr[15:12]) == BTS_OP_TEST_CLR)
    else $error("test decode wrong");
  a_skip_cause: assert property (is_bit_test_skip_clear_op |->
    flush == !$past(rd_data[instr[11:9]]))
    else $error("skip decision wrong");
  a_one_word: assert property ($rose(flush) && !$past(next_two_word) |=>
    !flush && !busy)
    else $error("one-word skip length wrong");
  a_two_word: assert property ($rose(flush) && $past(next_two_word) |=>
    flush ##1 !flush)
    else $error("two-word skip length wrong");
  a_flush_busy: assert property (flush |-> busy) else $error("flush without busy");
endmodule
bind bts_exec bts_exec_sva bts_exec_sva_i(.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr(instr), .bank_select_reg(bank_select_reg), .ext_set_en(ext_set_en), .rd_data(rd_data),
  .next_two_word(next_two_word), .rd_addr(rd_addr), .wr(wr), .flush(flush), .busy(busy),
  .is_bit_set_op(is_bit_set_op), .is_bit_test_skip_clear_op(is_bit_test_skip_clear_op));

// ---- sim/bit_set_and_test_skip_exec_tb_top.sv ----
// random bit-set, test-skip and foreign opcodes against the execution block
// expectations queue up at drive time; a negedge monitor compares them
`timescale 1ns/1ps
module bit_set_and_test_skip_exec_tb_top
  import bts_pkg::*;
();
  logic clk = 0, rst_n = 0, instr_valid = 0, next_two_word = 0, ext_set_en = 0;
  logic [15:0] instr = 16'h0000;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [7:0]  rd_data = 8'h00;
  logic [1:0]  exp_sk[$];
  bts_wr_t     wr, exp_wr[$];
  logic [11:0] rd_addr, exp_ad[$];
  logic        flush, busy, is_set, is_tst;
  int          failures = 0, comparisons = 0;
  bts_exec bts_exec_i(.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .bank_select_reg(bank_select_reg), .ext_set_en(ext_set_en), .rd_data(rd_data),
    .next_two_word(next_two_word), .rd_addr(rd_addr), .wr(wr), .flush(flush), .busy(busy),
    .is_bit_set_op(is_set), .is_bit_test_skip_clear_op(is_tst));
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task chk_wr(input bts_wr_t e);
    comparisons++;
    if (wr !== e) failures++;
    if (wr !== e) $display("unexpected wr: expected %h seen %h", e, wr);
  endtask
  task chk_skip(input logic [1:0] e, input logic [1:0] g);
    comparisons++;
    if (g !== e) failures++;
    if (g !== e) $display("unexpected flush count: expected %0d seen %0d", e, g);
  endtask
  task chk_addr(input logic [11:0] e);
    comparisons++;
    if (rd_addr !== e) failures++;
    if (rd_addr !== e) $display("unexpected rd_addr: expected %h seen %h", e, rd_addr);
  endtask
  task give_verdict;
    int left;
    left = exp_wr.size() + exp_sk.size() + exp_ad.size();
    comparisons++;
    if (left != 0) failures++;
    if (left != 0) $display("unexpected pending results: expected 0 seen %0d", left);
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // n = 0 keeps valid up so the next word (a test-skip) follows a bit-set back to back
  task issue(input logic [3:0] op, input logic [2:0] b, input int n);
    logic [7:0]  f, d;
    logic [3:0]  k;
    logic        a, x, t;
    logic [11:0] ea;
    bts_mode_t   em;
    f = 8'($urandom);
    d = 8'($urandom);
    k = 4'($urandom);
    {a, x, t} = 3'($urandom);
    // odd bit numbers pull f into the indexed range, limit included
    if (b[0]) f = f % (BTS_INDEXED_LIMIT + 8'h01);
    em = a ? BTS_MODE_BANKED
      : (x && f <= BTS_INDEXED_LIMIT) ? BTS_MODE_INDEXED : BTS_MODE_ACCESS;
    ea = a ? {k, f} : {f[7] ? 4'hF : 4'h0, f};
    instr_valid <= 1'b1;
    instr <= {op, b, a, f};
    {rd_data, bank_select_reg, ext_set_en, next_two_word} <= {d, k, x, t};
    if (op == BTS_OP_SET)
      exp_wr.push_back('{we: 1'b1, addr: ea, data: d | (8'h01 << b), mode: em});
    if (op == BTS_OP_SET || op == BTS_OP_TEST_CLR) exp_ad.push_back(ea);
    if (op == BTS_OP_TEST_CLR) exp_sk.push_back(d[b] ? 2'h0 : (t ? 2'h2 : 2'h1));
    @(posedge clk);
    if (n != 0) instr_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever
  begin
    logic [1:0] c;
    @(negedge clk);
    if (wr.we || is_tst) chk_addr(exp_ad.pop_front());
    if (wr.we) chk_wr(exp_wr.pop_front());
    if (is_tst)
    begin
      c = {1'b0, flush};
      @(negedge clk);
      chk_skip(exp_sk.pop_front(), c + flush);
    end
  end
  initial
  begin
    void'($urandom(57));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 60; i++)
      issue((i % 3 == 0) ? BTS_OP_SET : (i % 3 == 1) ? BTS_OP_TEST_CLR : 4'hA, 3'(i / 3),
        (i % 3 == 0 && i % 2 == 0) ? 0 : 3);
    give_verdict;
  end
endmodule
